// [adtc_defs.vh]
/*
  constants for the converter timing configuration block: register
  offsets, field positions, reset values and sequencer timing.
  assumes it is included by bare name from the top design file.
*/
`ifndef ADTC_DEFS_VH
`define ADTC_DEFS_VH

`define ADTC_TIMING_OFS 8'h00
`define ADTC_STATUS_OFS 8'h04
`define ADTC_SRC_BIT 15
`define ADTC_SAMC_HI 12
`define ADTC_SAMC_LO 8
`define ADTC_DIV_HI 7
`define ADTC_DIV_LO 0
`define ADTC_TIMING_MASK 16'h9FFF
`define ADTC_TIMING_RST 16'h0000
`define ADTC_ST_SAMPLING 16
`define ADTC_ST_CONVERTING 17
`define ADTC_CONV_TAD 12

`endif

// [adtc_tad_gen.v]
/*
  conversion clock tick generator: one mclk pulse per conversion
  clock period, either from the rc tick input or from mclk divided.
  assumes mclk is the instruction cycle and rc_tick is synchronous.
*/
module adtc_tad_gen #(
  parameter DIV_W = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire run,
  input wire src_rc,
  input wire [DIV_W-1:0] div,
  input wire rc_tick,
  output reg tad_tick
);

  reg [DIV_W-1:0] cnt;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt <= {DIV_W{1'b0}};
      tad_tick <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        // restart divider phase so each mclk-divided conversion starts on a full period
        cnt <= {DIV_W{1'b0}};
        tad_tick <= 1'b0;
      end
      else if (src_rc)
      begin
        tad_tick <= rc_tick;
        cnt <= {DIV_W{1'b0}};
      end
      else if (cnt == div)
      begin
        // period is div + 1 instruction cycles
        tad_tick <= 1'b1;
        cnt <= {DIV_W{1'b0}};
      end
      else
      begin
        tad_tick <= 1'b0;
        cnt <= cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [adtc_top.v]
/*
  converter timing configuration: ahb-lite register slave holding the
  timing register, plus a sample/convert sequencer timed by it.
  assumes a single ahb-lite master, word transfers, and conv_start
  as a one-cycle pulse synchronous to mclk.
*/
// Design decisions made here: the register offsets and the AHB-Lite slave port.
// Summary of operation
// - source bit one selects rc clock ticks
// - bits 14 and 13 read zero, ignore writes
// - sample field counts sampling in conversion periods
// - implemented fields read/write, reset to zero
// - period equals instruction cycle times divider plus one
// - sample field zero gives zero sampling periods
`include "adtc_defs.vh"

module adtc_top #(
  parameter CONV_TAD = `ADTC_CONV_TAD
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire conv_start,
  input wire rc_tick,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output wire tad_tick,
  output reg sampling,
  output reg converting,
  output reg conv_done
);

  localparam ST_IDLE = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONVERT = 2'b10;

  reg [15:0] timing;
  reg [15:0] next_timing;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg [1:0] state;
  reg act_src;
  reg [4:0] act_samc;
  reg [7:0] act_div;
  reg [4:0] tad_cnt;
  reg [31:0] next_rdata;
  wire addr_ph;
  wire [15:0] status_lo;
  wire seq_end;

  // registered read data needs the value a write in flight will leave
  function [31:0] adtc_read;
    input [7:0] addr;
    input [15:0] tval;
    input [15:0] sval;
    input samp;
    input conv;
    begin
      adtc_read = 32'h00000000;
      if (addr == `ADTC_TIMING_OFS)
        adtc_read = {16'h0000, tval & `ADTC_TIMING_MASK};
      else if (addr == `ADTC_STATUS_OFS)
      begin
        adtc_read[15:0] = sval;
        adtc_read[`ADTC_ST_SAMPLING] = samp;
        adtc_read[`ADTC_ST_CONVERTING] = conv;
      end
    end
  endfunction

  assign addr_ph = hsel & htrans[1] & hready;
  assign status_lo = {act_src, 2'b00, act_samc, act_div};
  // stop the divider on the last tick, else a stray tick follows done
  assign seq_end = (state == ST_CONVERT) & tad_tick & (tad_cnt == CONV_TAD[4:0] - 5'h01);

  always @*
  begin
    next_timing = timing;
    if (wr_pend && (wr_addr == `ADTC_TIMING_OFS))
      next_timing = hwdata[15:0] & `ADTC_TIMING_MASK;
  end

  always @*
  begin
    next_rdata = adtc_read(haddr[7:0], next_timing, status_lo, sampling, converting);
    if (haddr[31:8] != 24'h000000)
      next_rdata = 32'h00000000;
  end

  // bus slave: zero wait states, always okay
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      timing <= `ADTC_TIMING_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      timing <= next_timing;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ph & hwrite & (haddr[31:8] == 24'h000000) & (hsize == 3'b010);
      wr_addr <= haddr[7:0];
      if (addr_ph && !hwrite)
        hrdata <= next_rdata;
    end
  end

  adtc_tad_gen #(
    .DIV_W(8)
  ) u_tad (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run((state != ST_IDLE) & ~seq_end),
    .src_rc(act_src),
    .div(act_div),
    .rc_tick(rc_tick),
    .tad_tick(tad_tick)
  );

  // sequencer works only from the copy taken at start
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      act_src <= 1'b0;
      act_samc <= 5'h00;
      act_div <= 8'h00;
      tad_cnt <= 5'h00;
      sampling <= 1'b0;
      converting <= 1'b0;
      conv_done <= 1'b0;
    end
    else if (ce)
    begin
      conv_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (conv_start)
          begin
            act_src <= timing[`ADTC_SRC_BIT];
            act_div <= timing[`ADTC_DIV_HI:`ADTC_DIV_LO];
            act_samc <= timing[`ADTC_SAMC_HI:`ADTC_SAMC_LO];
            tad_cnt <= 5'h00;
            if (timing[`ADTC_SAMC_HI:`ADTC_SAMC_LO] == 5'h00)
            begin
              state <= ST_CONVERT;
              converting <= 1'b1;
            end
            else
            begin
              state <= ST_SAMPLE;
              sampling <= 1'b1;
            end
          end
        end
        ST_SAMPLE:
        begin
          if (tad_tick)
          begin
            if (tad_cnt == act_samc - 5'h01)
            begin
              // sampled for exactly act_samc periods
              state <= ST_CONVERT;
              sampling <= 1'b0;
              converting <= 1'b1;
              tad_cnt <= 5'h00;
            end
            else
              tad_cnt <= tad_cnt + 5'h01;
          end
        end
        ST_CONVERT:
        begin
          if (tad_tick)
          begin
            if (tad_cnt == CONV_TAD[4:0] - 5'h01)
            begin
              state <= ST_IDLE;
              converting <= 1'b0;
              conv_done <= 1'b1;
              tad_cnt <= 5'h00;
            end
            else
              tad_cnt <= tad_cnt + 5'h01;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          sampling <= 1'b0;
          converting <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [adtc_top_props.sv]
/* port checker for adtc_top.
   assumes hready is fed back from hreadyout. */
module adtc_top_props #(
  parameter CONV_TAD = 12
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire conv_start,
  input wire rc_tick,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire tad_tick,
  input wire sampling,
  input wire converting,
  input wire conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  reg rd0;
  // timing read seen one cycle late, when hrdata stands
  always @(posedge mclk)
  begin
    rd0 <= ce & hsel & htrans[1] & hready & !hwrite & (haddr == 32'h0);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_start_begins:
    assert property (conv_start && !sampling && !converting && ce |=> sampling || converting)
    else $error("start not taken");
  a_phases_apart:
    assert property (!(sampling && converting)) else $error("both phases");
  a_sample_to_conv:
    assert property ($fell(sampling) |-> converting) else $error("no convert phase");
  a_done_end:
    assert property ($fell(converting) |-> conv_done) else $error("no done");
  a_done_pulse:
    assert property (conv_done |=> !conv_done) else $error("done too long");
  a_tick_busy:
    assert property (tad_tick |-> sampling || converting) else $error("idle tick");
  a_busy_ignore:
    assert property (sampling && conv_start |=> sampling || converting) else $error("restart");
  a_read_zero:
    assert property (rd0 |-> hrdata[14:13] == 2'h0 && hrdata[31:16] == 16'h0)
    else $error("bad unimplemented bits");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not okay");
endmodule
bind adtc_top adtc_top_props #(.CONV_TAD(CONV_TAD)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hwdata(hwdata), .conv_start(conv_start), .rc_tick(rc_tick),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tad_tick(tad_tick),
  .sampling(sampling), .converting(converting), .conv_done(conv_done));

// [testbench.sv]
/* bench for adtc_top: ahb-lite register access and timed conversions.
   assumes hreadyout loops back as hready; rc ticks every 5 cycles. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NT = 4;
  reg mclk = 0, sys_rst = 1, ce = 1, hsel = 0, hwrite = 0, conv_start = 0, rc_tick = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0;
  reg [2:0] hsize = 3'h2;
  wire [31:0] hrdata;
  wire hready, hresp, tad_tick, sampling, converting, conv_done;
  integer bad_count = 0, compares = 0, rc_cnt = 0;
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 4);
  end
  adtc_top #(.CONV_TAD(NT)) u_adtc_top (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .conv_start(conv_start), .rc_tick(rc_tick),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .tad_tick(tad_tick),
    .sampling(sampling), .converting(converting), .conv_done(conv_done));
  task chk(input string n, input [31:0] e, input [31:0] s);
    compares = compares + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("mismatch %0s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    @(posedge mclk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("okay response", 0, hresp);
  endtask
  // sp: tick spacing, nt: all ticks, ns: ticks while sampling
  task conv(input integer sp, input integer nt, input integer ns);
    integer i, last, ticks, st, gap;
    ticks = 0;
    st = 0;
    gap = 0;
    last = -1;
    @(posedge mclk);
    conv_start <= 1;
    @(posedge mclk);
    conv_start <= 0;
    for (i = 0; i < 500 && conv_done !== 1'b1; i = i + 1)
    begin
      @(posedge mclk);
      #1;
      // start pulse while busy must be ignored
      if (i == 1) conv_start <= 1;
      if (i == 2) conv_start <= 0;
      if (tad_tick === 1'b1)
      begin
        ticks = ticks + 1;
        if (sampling === 1'b1) st = st + 1;
        if (last >= 0 && i - last != sp) gap = gap + 1;
        last = i;
      end
    end
    chk("done seen", 1, conv_done);
    chk("idle after done", 0, {sampling, converting});
    chk("ticks", nt, ticks);
    chk("sample ticks", ns, st);
    chk("spacing", 0, gap);
  endtask
  task tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 0;
    bus(0, 0, 0);
    chk("reset value", 0, rd);
    bus(1, 0, 32'hFFFF_FF3F);
    bus(0, 0, 0);
    chk("timing", 32'h0000_9F3F, rd);
    bus(0, 32'h40, 0);
    chk("unmapped", 0, rd);
    bus(1, 0, 32'h0000_0302);
    // a source change mid-run must not disturb the spacing
    fork
      conv(3, 3 + NT, 3);
      bus(1, 0, 32'h0000_8100);
    join
    bus(0, 32'h04, 0);
    chk("status copy", 32'h0000_0302, rd);
    bus(0, 0, 0);
    chk("new timing", 32'h0000_8100, rd);
    conv(5, 1 + NT, 1);
    bus(1, 0, 32'h0000_0000);
    conv(1, NT, 0);
    bus(1, 0, 32'h0000_1F00);
    conv(1, 31 + NT, 31);
    bus(1, 0, 32'h0000_013F);
    conv(64, 1 + NT, 1);
    // halfword, frozen and status writes all leave timing alone
    hsize <= 3'h1;
    bus(1, 0, 32'h0000_9F3F);
    hsize <= 3'h2;
    ce <= 1'b0;
    bus(1, 0, 32'h0000_9F3F);
    ce <= 1'b1;
    bus(1, 32'h04, 32'h0000_FFFF);
    bus(0, 0, 0);
    chk("ignored writes", 32'h0000_013F, rd);
    tally_and_finish;
  end
endmodule
